// *** rtl/ias_pkg.sv ***
// Types shared by the acknowledge and stop sequencer
package ias_pkg;
  // Sequencer phases
  typedef enum logic [3:0] {
    IAS_IDLE, IAS_ACK_LOW, IAS_ACK_RISE, IAS_ACK_HIGH,
    IAS_STOP_LOW, IAS_STOP_CNT, IAS_STOP_SCLR, IAS_STOP_HIGH,
    IAS_STOP_REL, IAS_STOP_END
  } ias_state_t;
  // Sticky event flags, same layout for status and mask
  typedef struct packed {
    logic stop_det;
    logic write_collision_flag;
    logic irq_flag;
  } ias_flags_t;
endpackage : ias_pkg

// *** rtl/ias_regs.svh ***
// Register offsets, field positions and the baud reload reset value
`ifndef IAS_REGS_SVH
`define IAS_REGS_SVH
`define IAS_OFS_CTRL   5'h00
`define IAS_OFS_STAT   5'h04
`define IAS_OFS_MASK   5'h08
`define IAS_OFS_BAUD   5'h0c
`define IAS_OFS_XBUF   5'h10
`define IAS_CTRL_ACK_SEQUENCE_ENABLE 0
`define IAS_CTRL_ACK_DATA_VALUE 1
`define IAS_CTRL_PEN   2
`define IAS_ST_IRQ     0
`define IAS_ST_WRITE_COLLISION_FLAG    1
`define IAS_ST_STOP    2
`define IAS_ST_BUSY    3
`define IAS_ST_HOLD    4
`define IAS_BAUD_RST   8'h63
`endif

// *** rtl/ias_sequencer.sv ***
// I2C master acknowledge and stop sequencer with Avalon-MM register slave
// Operation
// RL1: Ack enable pulls clock low, shows ack data
// RL2: Software chooses ack data before starting
// RL3: One rollover later, release clock line
// RL4: Clock sampled high, one rollover, drive low
// RL5: Ack end: clear enable, stop counter, idle
// RL6: Buffer write during ack: collision, discarded
// RL7: Clock held low after ninth falling edge
// RL8: Stop enable drives data line low
// RL9: Data sampled low, reload, timeout releases clock
// RL10: One rollover later, release data line
// RL11: Data high while clock high: stop detected
// RL12: One rollover later: clear enable, set irq
// RL13: Buffer write during stop: collision, ignored
// RL14: Flags sticky; no start while busy
//
// Chosen here: the address map and register access over Avalon-MM.
`timescale 1ns/1ps
`include "ias_regs.svh"
module ias_sequencer (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [4:0]  av_address,
  input  wire logic        av_read,
  input  wire logic        av_write,
  input  wire logic [31:0] av_writedata,
  output logic      [31:0] av_readdata,
  output logic             av_waitrequest,
  input  wire logic        serial_clock_pin_in,
  output logic             serial_clock_pin_out,
  output logic             serial_clock_pin_oe,
  input  wire logic        serial_data_pin_in,
  output logic             serial_data_pin_out,
  output logic             serial_data_pin_oe,
  output logic             irq
);
  // Sequencer state and its next value
  ias_pkg::ias_state_t state;
  ias_pkg::ias_state_t next_state;
  // Control bits of serial_port_control_two
  logic       ack_sequence_enable;
  logic       ack_data_value;
  logic       stop_sequence_enable;
  logic       scl_hold;              // Clock parked low after a byte
  logic [7:0] baud_reload;           // Rollover reload value
  logic [7:0] brg_cnt;               // Rollover down counter
  logic [7:0] serial_transfer_buffer;
  // Sticky flags and their mask
  ias_pkg::ias_flags_t flags;
  ias_pkg::ias_flags_t mask;
  ias_pkg::ias_flags_t next_flags;
  ias_pkg::ias_flags_t flag_set;
  ias_pkg::ias_flags_t flag_clr;
  logic       bus_ack;               // One wait state then answer

  // Bus decode
  wire req        = av_read | av_write;
  wire take       = req & bus_ack;
  wire wr         = av_write & take;
  wire wr_ctrl    = wr & (av_address == `IAS_OFS_CTRL);
  wire wr_stat    = wr & (av_address == `IAS_OFS_STAT);
  wire wr_mask    = wr & (av_address == `IAS_OFS_MASK);
  wire wr_baud    = wr & (av_address == `IAS_OFS_BAUD);
  wire wr_xbuf    = wr & (av_address == `IAS_OFS_XBUF);
  wire busy       = (state != ias_pkg::IAS_IDLE);
  wire ack_go     = wr_ctrl & ~busy & av_writedata[`IAS_CTRL_ACK_SEQUENCE_ENABLE];
  wire stop_go    = wr_ctrl & ~busy & ~av_writedata[`IAS_CTRL_ACK_SEQUENCE_ENABLE]
                    & av_writedata[`IAS_CTRL_PEN];
  wire counting   = (state == ias_pkg::IAS_ACK_LOW)
                  | (state == ias_pkg::IAS_ACK_HIGH)
                  | (state == ias_pkg::IAS_STOP_CNT)
                  | (state == ias_pkg::IAS_STOP_HIGH)
                  | (state == ias_pkg::IAS_STOP_END);
  wire brg_tick   = counting & (brg_cnt == 8'h00);
  wire brg_load   = (next_state != state) | brg_tick;
  wire stop_seen  = (state == ias_pkg::IAS_STOP_REL)
                    & serial_data_pin_in & serial_clock_pin_in;
  wire seq_done   = brg_tick & ((state == ias_pkg::IAS_ACK_HIGH)
                    | (state == ias_pkg::IAS_STOP_END));

  // Read data mux
  wire [31:0] ctrl_rd = {29'h0, stop_sequence_enable, ack_data_value,
                         ack_sequence_enable};
  wire [31:0] stat_rd = {27'h0, scl_hold, busy, flags};
  wire [31:0] rd_mux =
      (av_address == `IAS_OFS_CTRL) ? ctrl_rd :
      (av_address == `IAS_OFS_STAT) ? stat_rd :
      (av_address == `IAS_OFS_MASK) ? {29'h0, mask} :
      (av_address == `IAS_OFS_BAUD) ? {24'h0, baud_reload} :
      (av_address == `IAS_OFS_XBUF) ? {24'h0, serial_transfer_buffer} :
      32'h0;

  // Waitrequest high in the first cycle of each request
  assign av_waitrequest = req & ~bus_ack;

  // Open-drain pins only ever pull low
  assign serial_clock_pin_out = 1'b0;
  assign serial_data_pin_out  = 1'b0;

  // Answer timing and registered read data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_ack     <= 1'b0;
      av_readdata <= 32'h0;
    end else begin
      bus_ack <= req & ~bus_ack;
      if (req & ~bus_ack) begin
        av_readdata <= rd_mux;
      end
    end
  end

  // Phase sequencing
  always_comb begin
    next_state = state;
    case (state)
      ias_pkg::IAS_IDLE: begin
        if (ack_go) begin
          next_state = ias_pkg::IAS_ACK_LOW;      // [RL1] [RL14]
        end else if (stop_go) begin
          next_state = ias_pkg::IAS_STOP_LOW;     // [RL8] [RL14]
        end
      end
      ias_pkg::IAS_ACK_LOW: begin
        if (brg_tick) begin
          next_state = ias_pkg::IAS_ACK_RISE;     // [RL3]
        end
      end
      ias_pkg::IAS_ACK_RISE: begin
        if (serial_clock_pin_in) begin
          next_state = ias_pkg::IAS_ACK_HIGH;     // [RL4]
        end
      end
      ias_pkg::IAS_ACK_HIGH: begin
        if (brg_tick) begin
          next_state = ias_pkg::IAS_IDLE;         // [RL4] [RL5]
        end
      end
      ias_pkg::IAS_STOP_LOW: begin
        if (!serial_data_pin_in) begin
          next_state = ias_pkg::IAS_STOP_CNT;     // [RL9]
        end
      end
      ias_pkg::IAS_STOP_CNT: begin
        if (brg_tick) begin
          next_state = ias_pkg::IAS_STOP_SCLR;    // [RL9]
        end
      end
      ias_pkg::IAS_STOP_SCLR: begin
        if (serial_clock_pin_in) begin
          next_state = ias_pkg::IAS_STOP_HIGH;
        end
      end
      ias_pkg::IAS_STOP_HIGH: begin
        if (brg_tick) begin
          next_state = ias_pkg::IAS_STOP_REL;     // [RL10]
        end
      end
      ias_pkg::IAS_STOP_REL: begin
        if (stop_seen) begin
          next_state = ias_pkg::IAS_STOP_END;     // [RL11]
        end
      end
      ias_pkg::IAS_STOP_END: begin
        if (brg_tick) begin
          next_state = ias_pkg::IAS_IDLE;         // [RL12]
        end
      end
      default: begin
        next_state = ias_pkg::IAS_IDLE;
      end
    endcase
  end

  // Pin drive per phase, registered from the next phase
  wire next_ack = (next_state == ias_pkg::IAS_ACK_LOW)
                | (next_state == ias_pkg::IAS_ACK_RISE)
                | (next_state == ias_pkg::IAS_ACK_HIGH);
  wire next_stop_sda = (next_state == ias_pkg::IAS_STOP_LOW)
                     | (next_state == ias_pkg::IAS_STOP_CNT)
                     | (next_state == ias_pkg::IAS_STOP_SCLR)
                     | (next_state == ias_pkg::IAS_STOP_HIGH);
  // Only an ack end parks the clock; a finished stop leaves the bus free
  wire ack_done  = seq_done & (state == ias_pkg::IAS_ACK_HIGH);
  wire next_hold = (scl_hold | ack_done) & ~stop_go
                   & (next_state == ias_pkg::IAS_IDLE);
  wire next_scl_oe = (next_state == ias_pkg::IAS_ACK_LOW)
                   | (next_state == ias_pkg::IAS_STOP_LOW)
                   | (next_state == ias_pkg::IAS_STOP_CNT)
                   | next_hold;
  wire next_ack_data_value = wr_ctrl ? av_writedata[`IAS_CTRL_ACK_DATA_VALUE] : ack_data_value;
  wire next_sda_oe = (next_ack & ~next_ack_data_value) | next_stop_sda;

  // State, pins and the rollover counter
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state               <= ias_pkg::IAS_IDLE;
      serial_clock_pin_oe <= 1'b0;
      serial_data_pin_oe  <= 1'b0;
      brg_cnt             <= 8'h00;
    end else begin
      state               <= next_state;
      serial_clock_pin_oe <= next_scl_oe;        // [RL1] [RL3] [RL7] [RL9]
      serial_data_pin_oe  <= next_sda_oe;        // [RL1] [RL8] [RL10]
      if (brg_load) begin
        brg_cnt <= baud_reload;                  // [RL9]
      end else if (counting && brg_cnt != 8'h00) begin
        brg_cnt <= brg_cnt - 8'h01;
      end
    end
  end

  // Control bits; the two enables self-clear at each sequence end, ack data keeps its value
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_sequence_enable  <= 1'b0;
      ack_data_value       <= 1'b0;
      stop_sequence_enable <= 1'b0;
      scl_hold             <= 1'b0;
      baud_reload          <= `IAS_BAUD_RST;
      mask                 <= '0;
    end else begin
      ack_data_value <= next_ack_data_value;
      scl_hold       <= next_hold;               // [RL7]
      if (ack_go) begin
        ack_sequence_enable <= 1'b1;
      end else if (seq_done) begin
        ack_sequence_enable <= 1'b0;             // [RL5]
      end
      if (stop_go) begin
        stop_sequence_enable <= 1'b1;
      end else if (seq_done) begin
        stop_sequence_enable <= 1'b0;            // [RL12]
      end
      if (wr_baud) begin
        baud_reload <= av_writedata[7:0];
      end
      if (wr_mask) begin
        mask <= av_writedata[2:0];
      end
    end
  end

  // Buffer write is discarded while a sequence runs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      serial_transfer_buffer <= 8'h00;
    end else if (wr_xbuf && !busy) begin
      serial_transfer_buffer <= av_writedata[7:0]; // [RL6] [RL13]
    end
  end

  // Sticky flags: set wins over write-one-to-clear
  always_comb begin
    flag_set          = '0;
    flag_set.irq_flag = seq_done & (state == ias_pkg::IAS_STOP_END);
    flag_set.write_collision_flag     = wr_xbuf & busy;          // [RL6] [RL13]
    flag_set.stop_det = stop_seen;               // [RL11]
    flag_clr          = wr_stat ? av_writedata[2:0] : 3'h0;
    next_flags        = (flags & ~flag_clr) | flag_set; // [RL14]
  end

  // Mask as it stands after this edge, so irq follows a mask write at once
  wire [2:0] next_mask = wr_mask ? av_writedata[2:0] : mask;

  // Flags and the level interrupt
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      flags <= '0;
      irq   <= 1'b0;
    end else begin
      flags <= next_flags;
      irq   <= |(next_flags & next_mask);
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_ack_start: assert property (ack_go |=> serial_clock_pin_oe && // [RL1]
      serial_data_pin_oe == !ack_data_value && ack_sequence_enable)
    else $error("ack start did not pull clock low");
  a_ack_release: assert property // [RL3]
    ((state == ias_pkg::IAS_ACK_LOW) && brg_tick |=> !serial_clock_pin_oe)
    else $error("clock not released after low rollover");
  a_ack_arbit: assert property // [RL4]
    ((state == ias_pkg::IAS_ACK_RISE) && !serial_clock_pin_in
      |=> state == ias_pkg::IAS_ACK_RISE && !serial_clock_pin_oe)
    else $error("clock high phase started before line high");
  a_ack_finish: assert property // [RL5]
    ((state == ias_pkg::IAS_ACK_HIGH) && brg_tick |=> !ack_sequence_enable
      && serial_clock_pin_oe && state == ias_pkg::IAS_IDLE)
    else $error("ack sequence did not end cleanly");
  a_write_collision_flag_discard: assert property // [RL6] [RL13]
    (wr_xbuf && busy |=> flags.write_collision_flag && $stable(serial_transfer_buffer))
    else $error("colliding buffer write not discarded");
  a_hold_idle: assert property // [RL7]
    (scl_hold && state == ias_pkg::IAS_IDLE && !bus_ack |-> serial_clock_pin_oe)
    else $error("clock not parked low after ack");
  a_stop_sda: assert property (stop_go |=> serial_data_pin_oe // [RL8]
      && stop_sequence_enable)
    else $error("stop start did not drive data low");
  a_stop_timeout: assert property // [RL9]
    ((state == ias_pkg::IAS_STOP_CNT) && brg_tick |=> !serial_clock_pin_oe
      && serial_data_pin_oe)
    else $error("clock not released at stop timeout");
  a_stop_release: assert property // [RL10]
    ((state == ias_pkg::IAS_STOP_HIGH) && brg_tick
      |=> !serial_data_pin_oe && !serial_clock_pin_oe)
    else $error("data line not released after high rollover");
  a_stop_detect: assert property (stop_seen |=> flags.stop_det) // [RL11]
    else $error("stop not flagged");
  a_stop_end: assert property // [RL12]
    ((state == ias_pkg::IAS_STOP_END) && brg_tick
      |=> !stop_sequence_enable && flags.irq_flag && !serial_clock_pin_oe)
    else $error("stop end did not raise flag");
  a_no_restart: assert property // [RL14]
    (busy && wr_ctrl && !seq_done
      |=> $stable(ack_sequence_enable) && $stable(stop_sequence_enable))
    else $error("sequence restarted while busy");

  c_ack_done: cover property ((state == ias_pkg::IAS_ACK_HIGH) && brg_tick);
  c_stop_done: cover property ((state == ias_pkg::IAS_STOP_END) && brg_tick);
  c_write_collision_flag: cover property (wr_xbuf && busy);
  c_irq: cover property ($rose(irq));
endmodule : ias_sequencer

// *** verification/ias_line_model.sv ***
// Open-drain bus lines with a clock-stretching slave on the far side
`timescale 1ns/1ps
module ias_line_model (
  input  wire logic       sys_clk,
  input  wire logic       scl_oe,
  input  wire logic       sda_oe,
  input  wire logic [7:0] stretch,
  output logic            scl_line,
  output logic            sda_line
);
  logic [7:0] hold_cnt = 8'h00; // Stretch cycles still to run
  logic       slave_pull;       // Slave holds the clock low
  // Reload while the master pulls, count down once it lets go
  always_ff @(posedge sys_clk) begin
    if (scl_oe) begin
      hold_cnt <= stretch;
    end else if (hold_cnt != 8'h00) begin
      hold_cnt <= hold_cnt - 8'h01;
    end
  end
  // Each clock release is held back by the slave for a while
  assign slave_pull = !scl_oe && (hold_cnt != 8'h00);
  // Pull-ups give a high level when nobody drives
  assign scl_line = !(scl_oe || slave_pull);
  assign sda_line = !sda_oe;
endmodule : ias_line_model

// *** verification/testbench.sv ***
// Self-checking bench for the acknowledge and stop sequencer
`timescale 1ns/1ps
`include "ias_regs.svh"
module testbench;
  localparam logic [7:0] RLD = 8'h04; // Baud reload used in the run
  logic        sys_clk, rst, av_read, av_write, av_waitrequest, irq;
  logic [4:0]  av_address;
  logic [31:0] av_writedata, av_readdata, rd;
  logic        scl_out, scl_oe, sda_out, sda_oe, scl_line, sda_line;
  logic [7:0]  stretch;
  logic [4:0]  mon;           // Watched signals by index
  int          num_errors, samples_checked, n;
  assign mon = {irq, sda_line, scl_line, sda_oe, scl_oe};
  ias_sequencer dut_u (.sys_clk(sys_clk), .rst(rst), .av_address(av_address),
    .av_read(av_read), .av_write(av_write), .av_writedata(av_writedata),
    .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .serial_clock_pin_in(scl_line), .serial_clock_pin_out(scl_out),
    .serial_clock_pin_oe(scl_oe), .serial_data_pin_in(sda_line),
    .serial_data_pin_out(sda_out), .serial_data_pin_oe(sda_oe), .irq(irq));
  ias_line_model line_u (.sys_clk(sys_clk), .scl_oe(scl_oe), .sda_oe(sda_oe),
    .stretch(stretch), .scl_line(scl_line), .sda_line(sda_line));
  // 40 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // Verdict and end of run
  task results;
    $display("checked %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  // Compare seen against expected
  task check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check
  // One Avalon transfer, held until waitrequest is seen low
  task bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int k;
    @(posedge sys_clk);
    av_address <= a;
    av_write <= wr;
    av_read <= !wr;
    av_writedata <= d;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (av_waitrequest !== 1'b0 && k < 50);
    rd = av_readdata;
    av_write <= 1'b0;
    av_read <= 1'b0;
    if (k >= 50) begin
      num_errors++;
      results();
    end
  endtask : bus
  // Count edges until a watched signal reaches a level
  task wait_sig(input int sel, input logic lvl);
    n = 0;
    #1;
    while (mon[sel] !== lvl && n < 300) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (n >= 300) begin
      num_errors++;
      results();
    end
  endtask : wait_sig
  // Reset values, unmapped place, reload setting
  task t_reset;
    check(scl_out, 1'b0);
    check(sda_out, 1'b0);
    bus(0, `IAS_OFS_BAUD, 0);
    check(rd, {24'h0, `IAS_BAUD_RST});
    bus(0, `IAS_OFS_STAT, 0);
    check(rd, 32'h0);
    bus(0, 5'h14, 0);
    check(rd, 32'h0);
    bus(1, `IAS_OFS_BAUD, {24'h0, RLD});
    bus(0, `IAS_OFS_BAUD, 0);
    check(rd, {24'h0, RLD});
    $display("test reset done");
  endtask : t_reset
  // Acknowledge with stretch and a colliding buffer write
  task t_ack;
    bus(1, `IAS_OFS_XBUF, 32'h3c);
    bus(1, `IAS_OFS_CTRL, 32'h1); // Ack data zero
    wait_sig(0, 1'b1);
    check(n, 0);
    wait_sig(1, 1'b1);
    check(n, 0);
    wait_sig(0, 1'b0);
    check(n, RLD + 1);
    bus(1, `IAS_OFS_XBUF, 32'ha5);
    wait_sig(2, 1'b1);
    wait_sig(0, 1'b1);
    check(n, RLD + 2);
    check(sda_oe, 1'b0);
    bus(0, `IAS_OFS_CTRL, 0);
    check(rd, 32'h0);
    bus(0, `IAS_OFS_STAT, 0);
    check(rd, 32'h12);
    bus(0, `IAS_OFS_XBUF, 0);
    check(rd, 32'h3c);
    $display("test ack done");
  endtask : t_ack
  // Stop with refused start, collision and interrupt handling
  task t_stop;
    bus(1, `IAS_OFS_STAT, 32'h7);
    bus(0, `IAS_OFS_STAT, 0);
    check(rd, 32'h10);
    bus(1, `IAS_OFS_MASK, 32'h1);
    bus(1, `IAS_OFS_CTRL, 32'h4);
    wait_sig(1, 1'b1);
    check(n, 0);
    wait_sig(0, 1'b0);
    check(n >= RLD + 1 && n <= RLD + 3, 1'b1);
    bus(1, `IAS_OFS_XBUF, 32'h5a);
    bus(1, `IAS_OFS_CTRL, 32'h1);
    wait_sig(2, 1'b1);
    wait_sig(1, 1'b0);
    check(n, RLD + 2);
    wait_sig(4, 1'b1);
    check(n >= RLD + 2 && n <= RLD + 4, 1'b1);
    bus(0, `IAS_OFS_STAT, 0);
    check(rd, 32'h7);
    bus(0, `IAS_OFS_CTRL, 0);
    check(rd, 32'h0);
    check(scl_oe, 1'b0);
    bus(0, `IAS_OFS_XBUF, 0);
    check(rd, 32'h3c);
    bus(1, `IAS_OFS_STAT, 32'h1);
    wait_sig(4, 1'b0);
    check(n <= 2, 1'b1);
    bus(1, `IAS_OFS_MASK, 32'h4);
    wait_sig(4, 1'b1);
    check(n <= 2, 1'b1);
    bus(0, `IAS_OFS_STAT, 0);
    check(rd, 32'h6);
    $display("test stop done");
  endtask : t_stop
  // Not-acknowledge, with a stop request written alongside that must lose
  task t_nack;
    bus(1, `IAS_OFS_CTRL, 32'h7); // Ack data one
    wait_sig(0, 1'b1);
    check(n, 0);
    check(sda_oe, 1'b0);
    wait_sig(0, 1'b0);
    check(n, RLD + 1);
    check(sda_oe, 1'b0);
    wait_sig(2, 1'b1);
    wait_sig(0, 1'b1);
    check(n, RLD + 2);
    bus(0, `IAS_OFS_CTRL, 0);
    check(rd, 32'h2);
    $display("test nack done");
  endtask : t_nack
  // Main sequence
  initial begin
    rst = 1'b1;
    av_address = 5'h00;
    av_read = 1'b0;
    av_write = 1'b0;
    av_writedata = 32'h0;
    stretch = 8'h14;
    num_errors = 0;
    samples_checked = 0;
    repeat (4) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_ack();
    t_stop();
    t_nack();
    results();
  end
endmodule : testbench
